// *** src/iaus_pkg.sv ***
// Package: register map, command encodings and timing counts of the in-app update sequencer
package iaus_pkg;
    // Register offsets (special-function addresses)
    localparam logic [7:0] CHIP_CONTROL_OFF  = 8'h9F;
    localparam logic [7:0] FLASH_TRIG_OFF    = 8'hA4;
    localparam logic [7:0] TIMED_KEY_OFF     = 8'hC7;
    localparam logic [7:0] ADDR_LOW_OFF      = 8'hA7;
    localparam logic [7:0] ADDR_HIGH_OFF     = 8'hA6;
    localparam logic [7:0] FLASH_DATA_OFF    = 8'hAE;
    localparam logic [7:0] FLASH_CMD_OFF     = 8'hAF;
    localparam logic [7:0] BLOCK_UPD_EN_OFF  = 8'hA5;
    localparam logic [7:0] CONFIG_TWO_OFF    = 8'hA3;
    localparam logic [7:0] IRQ_STATUS_OFF    = 8'hA1;
    localparam logic [7:0] IRQ_MASK_OFF      = 8'hA2;
    // Field positions
    localparam int PROG_EN_POS   = 0;
    localparam int FAULT_POS     = 6;
    localparam int GO_POS        = 0;
    localparam int INHIBIT_POS   = 3;
    localparam int WEN_POS       = 5;
    localparam int CEN_POS       = 4;
    localparam int BLK_LSB       = 6;
    // Block update enable bits
    localparam int UEN_MAIN_POS  = 0;
    localparam int UEN_LOAD_POS  = 1;
    localparam int UEN_CFG_POS   = 2;
    // Interrupt status bits
    localparam int EV_DONE_POS   = 0;
    localparam int EV_FAULT_POS  = 1;
    // Reset values
    localparam logic [7:0] CONFIG_TWO_RST = 8'hFF;
    localparam logic [7:0] ZERO_RST       = 8'h00;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    // Timed-access key bytes
    localparam logic [7:0] KEY_FIRST  = 8'hAA;
    localparam logic [7:0] KEY_SECOND = 8'h55;
    // Block select codes
    localparam logic [1:0] BLK_MAIN   = 2'h0;
    localparam logic [1:0] BLK_LOADER = 2'h1;
    localparam logic [1:0] BLK_CONFIG = 2'h3;
    // Function codes
    localparam logic [3:0] FC_READ    = 4'h0;
    localparam logic [3:0] FC_PROG    = 4'h1;
    localparam logic [3:0] FC_ERASE   = 4'h2;
    localparam logic [3:0] FC_UID     = 4'h4;
    localparam logic [3:0] FC_MAKER   = 4'hB;
    localparam logic [3:0] FC_PART    = 4'hC;
    // Array geometry
    localparam int MAIN_BYTES   = 18432;
    localparam int LOADER_BYTES = 4096;
    localparam int CFG_BYTES    = 5;
    localparam int UID_BYTES    = 12;
    localparam int PAGE_BITS    = 7;
    localparam int PAGE_BYTES   = 128;
    // Timing
    localparam int CLK_MHZ        = 100;
    localparam int ERASE_TIME_US  = 28000;
    localparam int PROG_TIME_US   = 50;
    localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
    localparam int CNT_W          = 22;
endpackage

// *** src/iaus_key_window.sv ***
// Timed-access window: two key bytes open a one-write window for protected registers
`timescale 1ns/1ps
`default_nettype none
module iaus_key_window (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Bus observation
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Window state
    output logic            open
);
    typedef enum logic [1:0] {KW_IDLE, KW_HALF, KW_OPEN} iaus_kw_t;
    typedef struct packed {
        iaus_kw_t st;
    } iaus_kw_state_t;
    iaus_kw_state_t s_q, s_d;

    // Key sequence; any other write after the second key closes the window
    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            if (wr_addr == iaus_pkg::TIMED_KEY_OFF && wr_data == iaus_pkg::KEY_FIRST) begin
                s_d.st = KW_HALF;
            end else if (wr_addr == iaus_pkg::TIMED_KEY_OFF && wr_data == iaus_pkg::KEY_SECOND
                         && s_q.st == KW_HALF) begin
                s_d.st = KW_OPEN;
            end else begin
                s_d.st = KW_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: KW_IDLE};
        end else begin
            s_q <= s_d;
        end
    end

    assign open = (s_q.st == KW_OPEN);

    // Window lasts only for the next write
    window_single_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        open && wr_en |=> !open || $past(wr_addr) == iaus_pkg::TIMED_KEY_OFF)
        else $error("key window stayed open after a write");
endmodule
`default_nettype wire

// *** src/iaus_op_timer.sv ***
// Down-counter that times erase and program pulses independent of the bus
`timescale 1ns/1ps
`default_nettype none
module iaus_op_timer (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rstn,
    // Control
    input  wire logic                      load,
    input  wire logic [iaus_pkg::CNT_W-1:0] cycles,
    // Status
    output logic                           done
);
    typedef struct packed {
        logic [iaus_pkg::CNT_W-1:0] cnt;
        logic                       run;
    } iaus_tm_state_t;
    iaus_tm_state_t s_q, s_d;

    // Count down; done pulses on the last cycle
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.cnt = cycles;
            s_d.run = 1'b1;
        end else if (s_q.run) begin
            s_d.cnt = s_q.cnt - 1'b1;
            if (s_q.cnt == {{(iaus_pkg::CNT_W-1){1'b0}}, 1'b1}) begin
                s_d.run = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{cnt: '0, run: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.run && (s_q.cnt == {{(iaus_pkg::CNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// *** src/iaus_sequencer.sv ***
// In-application flash update sequencer with register port, arrays and CPU stall
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) Software sets the program-enable bit before any update can start.
// (R2) Erase or program proceeds only if the target block's enable bit is set.
// (R3) Software loads address, data and command before triggering.
// (R4) Writing one to trigger bit 0 starts, only inside an open key window.
// (R5) CPU is held while the operation runs, released on completion.
// (R6) Erase and program are timed internally: 28 ms page erase, 50 us program.
// (R7) Go bit clears on completion and always reads zero.
// (R8) Out-of-range address on a triggered request sets fault flag bit 6.
// (R9) Software reads the fault flag after each operation.
// (R10) With brown-out detect on and inhibit bit set, low supply blocks erase/program.
// (R11) Software disables interrupts before triggering.
// (R12) Key bytes AA then 55 open the window for the trigger write.
// (R13) Command holds block select, write-enable, chip-enable and function code.
// (R14) Codes read, program and erase with matching write-enable select the action.
// (R15) Maker and part identity read; block select ignored.
// (R16) Unique code read, one byte of twelve.
// (R17) Config erase at address zero erases all config bytes to FF.
// (R18) Config program addresses bytes 0, 1, 2 and 4; the range check also accepts byte 3.
// (R19) A faulted request changes no flash and releases the CPU at once.
module iaus_sequencer #(
    parameter logic [7:0] MAKER_ID   = 8'h11,  // Arbitrary value
    parameter logic [7:0] PART_ID_LO = 8'h22,  // Arbitrary value
    parameter logic [7:0] PART_ID_HI = 8'h33,  // Arbitrary value
    parameter int         ERASE_CYC  = iaus_pkg::ERASE_CYCLES,
    parameter int         PROG_CYC   = iaus_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Supply monitor
    input  wire logic       brownout_detect_en,
    input  wire logic       below_brownout_threshold,
    // System
    output logic            cpu_hold,
    output logic            irq
);
    typedef enum logic [1:0] {SQ_IDLE, SQ_BUSY, SQ_DONE} iaus_sq_t;
    typedef struct packed {
        iaus_sq_t   st;
        logic       prog_enable_bit;
        logic       op_fault_flag;
        logic [7:0] target_addr_high;
        logic [7:0] target_addr_low;
        logic [7:0] flash_data_reg;
        logic [7:0] flash_cmd_reg;
        logic [7:0] block_update_enable;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [7:0] rdata;
        logic       erase_op;
    } iaus_sq_state_t;
    iaus_sq_state_t s_q, s_d;

    // Arrays: held outside the struct since they are memories
    logic [7:0] main_mem   [iaus_pkg::MAIN_BYTES];
    logic [7:0] loader_mem [iaus_pkg::LOADER_BYTES];
    logic [7:0] cfg_mem    [iaus_pkg::CFG_BYTES];
    logic [7:0] uid_rom    [iaus_pkg::UID_BYTES];

    logic                        key_open;
    logic                        tm_load;
    logic                        tm_done;
    logic [iaus_pkg::CNT_W-1:0]  tm_cycles;
    logic [15:0]                 addr;
    logic [1:0]                  blk;
    logic [3:0]                  fcode;
    logic                        wen;
    logic                        cen;
    logic                        go_wr;
    logic                        addr_ok;
    logic                        blk_allowed;
    logic                        inhibit;
    logic                        is_modify;
    logic [7:0]                  rd_byte;
    logic                        mem_we;

    iaus_key_window u_key (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wr_en   (reg_wr),
        .wr_addr (reg_addr),
        .wr_data (reg_wdata),
        .open    (key_open)
    );

    iaus_op_timer u_tm (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .load    (tm_load),
        .cycles  (tm_cycles),
        .done    (tm_done)
    );

    // Address range check per block; used only by the trigger check, for read and modify commands alike
    function automatic logic in_range(input logic [1:0] b, input logic [3:0] f,
                                      input logic [15:0] a);
        logic ok;
        ok = 1'b0;
        if (f == iaus_pkg::FC_MAKER) begin
            ok = 1'b1;
        end else if (f == iaus_pkg::FC_PART) begin
            ok = (a < 16'h0002);
        end else if (f == iaus_pkg::FC_UID) begin
            ok = (a < 16'(iaus_pkg::UID_BYTES));
        end else if (b == iaus_pkg::BLK_MAIN) begin
            ok = (a < 16'(iaus_pkg::MAIN_BYTES));
        end else if (b == iaus_pkg::BLK_LOADER) begin
            ok = (a < 16'(iaus_pkg::LOADER_BYTES));
        end else if (b == iaus_pkg::BLK_CONFIG) begin
            ok = (f == iaus_pkg::FC_ERASE) ? (a == 16'h0000) : (a < 16'(iaus_pkg::CFG_BYTES));
        end
        return ok;
    endfunction

    // Command fields
    assign addr  = {s_q.target_addr_high, s_q.target_addr_low};
    assign blk   = s_q.flash_cmd_reg[iaus_pkg::BLK_LSB +: 2];  // R13
    assign wen   = s_q.flash_cmd_reg[iaus_pkg::WEN_POS];
    assign cen   = s_q.flash_cmd_reg[iaus_pkg::CEN_POS];
    assign fcode = s_q.flash_cmd_reg[3:0];

    // Trigger write is honoured only in the key window with programming enabled
    assign go_wr = reg_wr && reg_addr == iaus_pkg::FLASH_TRIG_OFF && key_open      // R4
                   && reg_wdata[iaus_pkg::GO_POS] && s_q.prog_enable_bit       // R1
                   && s_q.st == SQ_IDLE;
    assign is_modify = wen && !cen && (fcode == iaus_pkg::FC_PROG || fcode == iaus_pkg::FC_ERASE);
    assign addr_ok   = in_range(blk, fcode, addr);
    // Config block uses its own enable bit; select 10 has no block
    assign blk_allowed = (blk == iaus_pkg::BLK_MAIN) ? s_q.block_update_enable[iaus_pkg::UEN_MAIN_POS]
                       : (blk == iaus_pkg::BLK_LOADER) ? s_q.block_update_enable[iaus_pkg::UEN_LOAD_POS]
                       : (blk == iaus_pkg::BLK_CONFIG) ? s_q.block_update_enable[iaus_pkg::UEN_CFG_POS]
                       : 1'b0;                                                 // R2
    // Inhibit bit lives in config byte 2
    assign inhibit = brownout_detect_en && cfg_mem[2][iaus_pkg::INHIBIT_POS]
                     && below_brownout_threshold;                              // R10

    // Read data multiplexer for non-modifying commands
    always_comb begin
        rd_byte = s_q.flash_data_reg;
        if (!wen && !cen) begin
            if (fcode == iaus_pkg::FC_MAKER) begin
                rd_byte = MAKER_ID;                                            // R15
            end else if (fcode == iaus_pkg::FC_PART) begin
                rd_byte = addr[0] ? PART_ID_HI : PART_ID_LO;                   // R15
            end else if (fcode == iaus_pkg::FC_UID) begin
                rd_byte = uid_rom[addr[3:0]];                                  // R16
            end else if (fcode == iaus_pkg::FC_READ && blk == iaus_pkg::BLK_MAIN) begin
                rd_byte = main_mem[addr[14:0]];                                // R14
            end else if (fcode == iaus_pkg::FC_READ && blk == iaus_pkg::BLK_LOADER) begin
                rd_byte = loader_mem[addr[11:0]];
            end else if (fcode == iaus_pkg::FC_READ && blk == iaus_pkg::BLK_CONFIG) begin
                rd_byte = cfg_mem[addr[2:0]];
            end
        end
    end

    // Sequencer, registers and interrupt status
    always_comb begin
        s_d       = s_q;
        tm_load   = 1'b0;
        tm_cycles = '0;
        mem_we    = 1'b0;
        // Register writes
        if (reg_wr) begin
            if (reg_addr == iaus_pkg::CHIP_CONTROL_OFF && key_open) begin
                s_d.prog_enable_bit = reg_wdata[iaus_pkg::PROG_EN_POS];
                s_d.op_fault_flag   = reg_wdata[iaus_pkg::FAULT_POS];
            end else if (reg_addr == iaus_pkg::ADDR_HIGH_OFF) begin
                s_d.target_addr_high = reg_wdata;
            end else if (reg_addr == iaus_pkg::ADDR_LOW_OFF) begin
                s_d.target_addr_low = reg_wdata;
            end else if (reg_addr == iaus_pkg::FLASH_DATA_OFF) begin
                s_d.flash_data_reg = reg_wdata;
            end else if (reg_addr == iaus_pkg::FLASH_CMD_OFF) begin
                s_d.flash_cmd_reg = reg_wdata;
            end else if (reg_addr == iaus_pkg::BLOCK_UPD_EN_OFF && key_open) begin
                s_d.block_update_enable = reg_wdata;
            end else if (reg_addr == iaus_pkg::IRQ_MASK_OFF) begin
                s_d.irq_mask = reg_wdata;
            end
        end
        // Reading status clears it; events below win over the clear
        if (reg_rd && reg_addr == iaus_pkg::IRQ_STATUS_OFF) begin
            s_d.irq_status = iaus_pkg::ZERO_RST;
        end
        case (s_q.st)
            SQ_IDLE: begin
                if (go_wr) begin
                    if (!addr_ok || (is_modify && (!blk_allowed || inhibit))) begin
                        s_d.op_fault_flag = 1'b1;                              // R8
                        s_d.irq_status[iaus_pkg::EV_FAULT_POS] = 1'b1;
                        s_d.st = SQ_DONE;                                      // R19
                    end else if (is_modify) begin
                        s_d.erase_op = (fcode == iaus_pkg::FC_ERASE);
                        tm_load   = 1'b1;
                        tm_cycles = (fcode == iaus_pkg::FC_ERASE) ?
                                    iaus_pkg::CNT_W'(ERASE_CYC) : iaus_pkg::CNT_W'(PROG_CYC); // R6
                        s_d.st = SQ_BUSY;                                      // R5
                    end else begin
                        s_d.flash_data_reg = rd_byte;                          // R14
                        s_d.st = SQ_DONE;
                    end
                end
            end
            SQ_BUSY: begin
                if (tm_done) begin
                    mem_we = 1'b1;
                    s_d.st = SQ_DONE;
                end
            end
            default: begin
                s_d.irq_status[iaus_pkg::EV_DONE_POS] = 1'b1;
                s_d.st = SQ_IDLE;                                              // R7
            end
        endcase
        // Read data, one cycle after the strobe; go bit reads zero
        s_d.rdata = iaus_pkg::ZERO_RST;
        if (reg_rd) begin
            if (reg_addr == iaus_pkg::CHIP_CONTROL_OFF) begin
                s_d.rdata = {1'b0, s_q.op_fault_flag, 5'h00, s_q.prog_enable_bit};
            end else if (reg_addr == iaus_pkg::ADDR_HIGH_OFF) begin
                s_d.rdata = s_q.target_addr_high;
            end else if (reg_addr == iaus_pkg::ADDR_LOW_OFF) begin
                s_d.rdata = s_q.target_addr_low;
            end else if (reg_addr == iaus_pkg::FLASH_DATA_OFF) begin
                s_d.rdata = s_q.flash_data_reg;
            end else if (reg_addr == iaus_pkg::FLASH_CMD_OFF) begin
                s_d.rdata = s_q.flash_cmd_reg;
            end else if (reg_addr == iaus_pkg::BLOCK_UPD_EN_OFF) begin
                s_d.rdata = s_q.block_update_enable;
            end else if (reg_addr == iaus_pkg::CONFIG_TWO_OFF) begin
                s_d.rdata = cfg_mem[2];
            end else if (reg_addr == iaus_pkg::IRQ_STATUS_OFF) begin
                s_d.rdata = s_q.irq_status;
            end else if (reg_addr == iaus_pkg::IRQ_MASK_OFF) begin
                s_d.rdata = s_q.irq_mask;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: SQ_IDLE, prog_enable_bit: 1'b0, op_fault_flag: 1'b0,
                     target_addr_high: iaus_pkg::ZERO_RST, target_addr_low: iaus_pkg::ZERO_RST,
                     flash_data_reg: iaus_pkg::ZERO_RST, flash_cmd_reg: iaus_pkg::ZERO_RST,
                     block_update_enable: iaus_pkg::ZERO_RST, irq_status: iaus_pkg::ZERO_RST,
                     irq_mask: iaus_pkg::ZERO_RST, rdata: iaus_pkg::ZERO_RST, erase_op: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Flash arrays: not reset, they model non-volatile content; write only at pulse end
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            if (s_q.erase_op) begin
                if (blk == iaus_pkg::BLK_CONFIG) begin
                    for (int i = 0; i < iaus_pkg::CFG_BYTES; i++) begin
                        cfg_mem[i] <= iaus_pkg::ERASED_BYTE;                   // R17
                    end
                end else begin
                    for (int i = 0; i < iaus_pkg::PAGE_BYTES; i++) begin
                        if (blk == iaus_pkg::BLK_MAIN) begin
                            main_mem[{addr[14:iaus_pkg::PAGE_BITS], 7'(i)}] <=
                                iaus_pkg::ERASED_BYTE;
                        end else begin
                            loader_mem[{addr[11:iaus_pkg::PAGE_BITS], 7'(i)}] <=
                                iaus_pkg::ERASED_BYTE;
                        end
                    end
                end
            end else if (blk == iaus_pkg::BLK_MAIN) begin
                main_mem[addr[14:0]] <= main_mem[addr[14:0]] & s_q.flash_data_reg;
            end else if (blk == iaus_pkg::BLK_LOADER) begin
                loader_mem[addr[11:0]] <= loader_mem[addr[11:0]] & s_q.flash_data_reg;
            end else begin
                cfg_mem[addr[2:0]] <= cfg_mem[addr[2:0]] & s_q.flash_data_reg;  // R18
            end
        end
    end

    // Unique code: arbitrary fixed pattern
    always_comb begin
        for (int i = 0; i < iaus_pkg::UID_BYTES; i++) begin
            uid_rom[i] = 8'(8'hA0 + i);
        end
    end

    // Stall covers busy and the completion cycle
    assign cpu_hold  = go_wr || s_q.st != SQ_IDLE;                             // R5
    assign irq       = |(s_q.irq_status & s_q.irq_mask);
    assign reg_rdata = s_q.rdata;

    // Loading the program cycle count enters busy on the next cycle
    prog_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        tm_load && tm_cycles == iaus_pkg::CNT_W'(PROG_CYC) |=> s_q.st == SQ_BUSY) // R6
        else $error("program did not enter busy");
    fault_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        go_wr && !addr_ok |=> s_q.op_fault_flag && s_q.st == SQ_DONE ##1 !cpu_hold) // R19
        else $error("fault did not release CPU");
    fault_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        go_wr && !addr_ok |=> s_q.op_fault_flag)                               // R8
        else $error("fault flag not set");
    block_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        go_wr && is_modify && !blk_allowed |=> s_q.st != SQ_BUSY)              // R2
        else $error("disabled block started");
    inhibit_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        go_wr && is_modify && inhibit |=> s_q.st != SQ_BUSY)                   // R10
        else $error("brown-out did not inhibit");
    trig_key_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(s_q.st != SQ_IDLE) |-> $past(key_open))                          // R4
        else $error("trigger outside key window");
    hold_busy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_q.st == SQ_BUSY |-> cpu_hold)                                        // R5
        else $error("CPU not held while busy");
    go_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        reg_rd && reg_addr == iaus_pkg::FLASH_TRIG_OFF |=> reg_rdata == 8'h00) // R7
        else $error("go bit read nonzero");
    enable_need_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        reg_wr && reg_addr == iaus_pkg::FLASH_TRIG_OFF && !s_q.prog_enable_bit
        && s_q.st == SQ_IDLE |=> s_q.st == SQ_IDLE)                            // R1
        else $error("start without program enable");
endmodule
`default_nettype wire

// *** verif/iaus_supply_model.sv ***
// Supply monitor model: brown-out detection always on, low supply on request
`timescale 1ns/1ps
`default_nettype none
module iaus_supply_model (
    // Control from the bench
    input  wire logic low_req,
    // Supply status to the sequencer
    output logic      detect_en,
    output logic      below_level
);
    // Detection stays enabled so the inhibit bit and low_req together decide blocking
    assign detect_en   = 1'b1;
    assign below_level = low_req;
endmodule
`default_nettype wire

// *** verif/iaus_sequencer_tb_top.sv ***
// Testbench: table-driven register and flash operation checks of the update sequencer
`timescale 1ns/1ps
`default_nettype none
module iaus_sequencer_tb_top;
    // Bench signals
    logic       ref_clk    = 1'b0;
    logic       rstn       = 1'b0;
    logic [7:0] reg_addr   = 8'h00;
    logic [7:0] reg_wdata  = 8'h00;
    logic       reg_wr     = 1'b0;
    logic       reg_rd     = 1'b0;
    logic       supply_low = 1'b0;
    logic [7:0] reg_rdata;
    logic       bod_en;
    logic       bod_low;
    logic       cpu_hold;
    logic       irq;
    int         mismatches = 0;
    int         compares   = 0;
    int         cycles     = 0;
    // Rows {op, addr, value}: 0 write, 1 read and compare, 2 wait idle, 3 key, 4 supply
    logic [23:0] rows [$] = '{24'h03_0000, 24'h00_9F01, 24'h03_0000, 24'h00_A507,
        24'h00_A600, 24'h00_A710, 24'h00_AF22, 24'h03_0000, 24'h00_A401, 24'h02_0000,
        24'h00_AF00, 24'h03_0000, 24'h00_A401, 24'h02_0000, 24'h01_AEFF,
        24'h00_AEA5, 24'h00_AF21, 24'h03_0000, 24'h00_A401, 24'h02_0000,
        24'h00_AF00, 24'h03_0000, 24'h00_A401, 24'h02_0000, 24'h01_AEA5,
        24'h00_AF0B, 24'h03_0000, 24'h00_A401, 24'h02_0000, 24'h01_AE11,
        24'h00_A701, 24'h00_AFCC, 24'h03_0000, 24'h00_A401, 24'h02_0000, 24'h01_AE33,
        24'h01_A400, 24'h01_8000, 24'h01_A101, 24'h01_A100,
        24'h00_A700, 24'h00_AFE2, 24'h03_0000, 24'h00_A401, 24'h02_0000, 24'h01_A3FF,
        24'h04_0001, 24'h00_A710, 24'h00_AF21, 24'h03_0000, 24'h00_A401, 24'h02_0000,
        24'h01_9F41, 24'h01_A103};
    // Short erase and program counts keep the run brief
    iaus_sequencer #(.MAKER_ID(8'h11), .PART_ID_HI(8'h33), .ERASE_CYC(20), .PROG_CYC(5)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .brownout_detect_en(bod_en), .below_brownout_threshold(bod_low),
        .cpu_hold(cpu_hold), .irq(irq));
    iaus_supply_model i_supply (.low_req(supply_low), .detect_en(bod_en), .below_level(bod_low));
    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    // Key bytes open the window for the next protected write
    task automatic key();
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
    endtask
    // The CPU stays held until the operation ends; bounded wait
    task automatic idle();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (cpu_hold !== 1'b0 && n < 100);
        if (n >= 100) check(8'h01, 8'h00);
    endtask
    task automatic results();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(8'hA1, 8'h00);
        foreach (rows[i]) begin
            case (rows[i][23:16])
                8'h00: wr(rows[i][15:8], rows[i][7:0]);
                8'h01: rd(rows[i][15:8], rows[i][7:0]);
                8'h02: idle();
                8'h03: key();
                default: supply_low <= rows[i][0];
            endcase
        end
        // Fault clear, then out-of-range read; interrupt masked while triggering
        key();
        wr(8'h9F, 8'h01);
        rd(8'h9F, 8'h01);
        wr(8'hA6, 8'hFF);
        wr(8'hAF, 8'h00);
        key();
        wr(8'hA4, 8'h01);
        idle();
        wr(8'hA2, 8'h02);
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, irq}, 8'h01);
        rd(8'h9F, 8'h41);
        rd(8'hA1, 8'h03);
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, irq}, 8'h00);
        // Disabled main block and a trigger outside the key window change no flash
        supply_low <= 1'b0;
        key();
        wr(8'h9F, 8'h01);
        key();
        wr(8'hA5, 8'h06);
        wr(8'hA6, 8'h00);
        wr(8'hAE, 8'h00);
        wr(8'hAF, 8'h21);
        wr(8'hA4, 8'h01);
        rd(8'hA1, 8'h00);
        key();
        wr(8'hA4, 8'h01);
        idle();
        rd(8'h9F, 8'h41);
        wr(8'hAF, 8'h00);
        key();
        wr(8'hA4, 8'h01);
        idle();
        rd(8'hAE, 8'hA5);
        // Mid-run reset returns the mask to zero and drops program enable
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(8'hA2, 8'h00);
        key();
        wr(8'hA4, 8'h01);
        rd(8'hA1, 8'h00);
        results();
    end
endmodule
`default_nettype wire
